// [hdl/lof_pkg.sv]
// ********************************************************************
// Lock and overcurrent fault response constants and types
// ********************************************************************
package lof_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	// Core clock rate
	localparam int          CLK_MHZ         = 100;
	// Core clock period in ns
	localparam int          CLK_PERIOD_NS   = 10;
	// Clock cycles in one millisecond
	localparam int          CYC_PER_MS      = CLK_MHZ * 1000;
	// Stall retry interval in ms
	localparam int          STALL_RETRY_MS  = 100;
	// Stall retry interval in clock cycles
	localparam int unsigned STALL_RETRY_CYC = STALL_RETRY_MS * CYC_PER_MS;
	// Longest allowed clear and report latency in ms
	localparam int          CLEAR_MAX_MS    = 200;
	localparam int          REPORT_MAX_MS   = 200;

	// ****************************************************************
	// Widths and indices
	// ****************************************************************
	localparam int SENSE_W = 8;   // Sense converter sample width
	localparam int CUR_W   = 12;  // Phase current sample width
	localparam int NPH     = 3;   // Motor phases
	localparam int NSRC    = 4;   // Fault sources
	localparam int RTRY_W  = 32;  // Retry counter width
	localparam int SYNC_N  = 3;   // Pin synchroniser depth
	// Fault source indices
	localparam int SRC_SENSE = 0;
	localparam int SRC_STALL = 1;
	localparam int SRC_CMP   = 2;
	localparam int SRC_SMP   = 3;

	// ****************************************************************
	// Response select encoding
	// ****************************************************************
	localparam logic [3:0] SEL_REPORT_ONLY = 4'h8;  // Report, no action
	localparam int         SEL_BRAKE_BIT   = 1;     // Brake instead of low
	localparam int         SEL_RETRY_BIT   = 2;     // Retry instead of latch
	localparam int         SEL_OFF_BIT     = 3;     // No gate action
	localparam logic       SNS_SEL_RETRY   = 1'b1;  // Sense recovery retry

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [NPH-1:0] RST_GATE    = 3'h0;
	localparam logic [NPH-1:0] LS_ALL_ON   = 3'h7;
	localparam logic           RST_FLT_N   = 1'b1;
	localparam logic [2:0]     RST_STATUS  = 3'h0;

	// ****************************************************************
	// Types
	// ****************************************************************
	// Gate driver action
	typedef enum logic [1:0] {LOF_GATE_RUN, LOF_GATE_HIZ, LOF_GATE_BRAKE} lof_gate_e;
	// Recovery style
	typedef enum logic [1:0] {LOF_REC_NONE, LOF_REC_LATCH, LOF_REC_RETRY} lof_rec_e;
	// Decoded response of one fault
	typedef struct packed {
		lof_gate_e gate;
		logic      report;
		lof_rec_e  rec;
	} lof_rsp_s;
	// Gate drive for all phases
	typedef struct packed {
		logic [NPH-1:0] high_side_gate_output;
		logic [NPH-1:0] low_side_gate_output;
	} lof_gates_s;

endpackage

// [hdl/lof_fault_resp.sv]
// Functional notes
// - Sense latched mode pulls gates low, latches
// - Sense retry mode pulls low, retries later
// - Sense fault when sense exceeds trip level
// - Stall from speed, no motor, or BEMF
// - Stall select 0-1: pull low, latch
// - Stall select 2-3: brake low side, latch
// - Stall select 4-5: pull low, retry
// - Stall select 6-7: brake, retry
// - Stall select 8: report only
// - Stall select 9-15: ignore entirely
// - Comparator limit select 0-1: pull low, latch
// - Comparator limit select 2-3: brake, latch
// - Comparator limit select 4-5: pull low, retry
// - Comparator limit select 6-7: brake, retry
// - Comparator select 8 reports; 9-15 ignore
// - Sampled fault when current exceeds threshold
// - Sampled select 0-1: pull low, latch
// - Sampled select 2-3: brake, latch
// - Sampled select 4-5: pull low, retry
// - Sampled select 6-7: brake, retry
// - Sampled select 8 reports; 9-15 ignore
// - Latched faults hold until clear command
// - Latched beats retry beats report; longest wait
// - Pull low drives every gate low
// - Every reported fault drives fault pin low
`timescale 1ns/10ps
module lof_fault_resp #(
	parameter int unsigned RETRY_CYCLES = lof_pkg::STALL_RETRY_CYC
) (
	// Clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// Sense overcurrent
	input  wire logic [lof_pkg::SENSE_W-1:0]   sense_volt_i,
	input  wire logic [lof_pkg::SENSE_W-1:0]   sense_trip_level_i,
	input  wire logic                          sense_check_disable_i,
	input  wire logic                          sense_recovery_select_i,
	// Motor stall detection
	input  wire logic                          speed_abnormal_i,
	input  wire logic                          no_motor_i,
	input  wire logic                          bemf_abnormal_i,
	input  wire logic [3:0]                    stall_response_select_i,
	// Comparator stall current limit
	input  wire logic                          comparator_stall_trip_i,
	input  wire logic [3:0]                    comparator_stall_response_select_i,
	// Sampled stall current limit
	input  wire logic [lof_pkg::CUR_W-1:0]     phase_current_i,
	input  wire logic [lof_pkg::CUR_W-1:0]     sampled_stall_current_limit_i,
	input  wire logic [3:0]                    sampled_stall_response_select_i,
	// Host command
	input  wire logic                          fault_clear_command_i,
	// Gate drive
	input  wire lof_pkg::lof_gates_s           pwm_i,
	output lof_pkg::lof_gates_s                gates_o,
	// Reporting
	output logic                               fault_indicator_n_o,
	output logic                               drv_fault_status_o,
	output logic [2:0]                         control_fault_status_o,
	output logic                               retry_pending_o
);

	// ****************************************************************
	// Shared response decoder
	// ****************************************************************
	// one decoder
	function automatic lof_pkg::lof_rsp_s decode_sel(input logic [3:0] sel);
		lof_pkg::lof_rsp_s r;
		r.gate   = lof_pkg::LOF_GATE_RUN;
		r.report = 1'b0;
		r.rec    = lof_pkg::LOF_REC_NONE;
		if (sel == lof_pkg::SEL_REPORT_ONLY) begin
			r.report = 1'b1;
		end else if (!sel[lof_pkg::SEL_OFF_BIT]) begin
			r.report = 1'b1;
			r.gate   = sel[lof_pkg::SEL_BRAKE_BIT] ? lof_pkg::LOF_GATE_BRAKE
							       : lof_pkg::LOF_GATE_HIZ;
			r.rec    = sel[lof_pkg::SEL_RETRY_BIT] ? lof_pkg::LOF_REC_RETRY
							       : lof_pkg::LOF_REC_LATCH;
		end
		return r;
	endfunction

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic [lof_pkg::SYNC_N-1:0] cmp_sync_q;   // Comparator pin synchroniser
	logic                       cmp_lvl_q;    // Filtered comparator level
	logic [lof_pkg::NSRC-1:0]   cond;         // Live fault conditions
	lof_pkg::lof_rsp_s          rsp [lof_pkg::NSRC];  // Per source response
	logic [lof_pkg::NSRC-1:0]   is_latch;     // Source is latching
	logic [lof_pkg::NSRC-1:0]   is_retry;     // Source is retrying
	logic [lof_pkg::NSRC-1:0]   is_hiz;       // Source pulls gates low
	logic [lof_pkg::NSRC-1:0]   is_brake;     // Source brakes
	logic [lof_pkg::NSRC-1:0]   is_rep;       // Source is reported
	logic [lof_pkg::NSRC-1:0]   held_q;       // Faults in effect
	logic [lof_pkg::NSRC-1:0]   held_d;
	logic [lof_pkg::RTRY_W-1:0] retry_cnt_q;  // Retry wait counter
	logic                       retry_done;   // Retry wait elapsed
	logic                       any_ret_cond; // A retry fault still present
	logic                       ret_pend;     // A retry fault held
	logic [lof_pkg::NSRC-1:0]   lat_mask;     // Held latched faults
	logic [lof_pkg::NSRC-1:0]   sel_mask;     // Faults steering the gates
	lof_pkg::lof_gate_e         gmode;        // Resulting gate action
	lof_pkg::lof_gates_s        gates_q;      // Registered gate drive
	logic                       flt_n_q;      // Registered fault pin
	logic                       drv_st_q;     // Driver status bit
	logic [2:0]                 ctl_st_q;     // Controller status bits

	// ****************************************************************
	// Comparator pin synchroniser
	// ****************************************************************
	// Three stages, shift in the raw pin
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_sync_q <= '0;
		end else begin
			cmp_sync_q <= {cmp_sync_q[1:0], comparator_stall_trip_i};
		end
	end

	// Level changes only when stages two and three agree
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_lvl_q <= 1'b0;
		end else if (cmp_sync_q[1] == cmp_sync_q[2]) begin
			cmp_lvl_q <= cmp_sync_q[2];
		end
	end

	// ****************************************************************
	// Fault conditions
	// ****************************************************************
	// sense trip compare
	assign cond[lof_pkg::SRC_SENSE] = !sense_check_disable_i &&
					  (sense_volt_i > sense_trip_level_i);
	assign cond[lof_pkg::SRC_STALL] = speed_abnormal_i | no_motor_i | bemf_abnormal_i;
	assign cond[lof_pkg::SRC_CMP]   = cmp_lvl_q;
	assign cond[lof_pkg::SRC_SMP]   = phase_current_i > sampled_stall_current_limit_i;

	// ****************************************************************
	// Response per source
	// ****************************************************************
	// Sense has its own two-way select
	always_comb begin
		rsp[lof_pkg::SRC_SENSE].gate   = lof_pkg::LOF_GATE_RUN;
		rsp[lof_pkg::SRC_SENSE].report = 1'b0;
		rsp[lof_pkg::SRC_SENSE].rec    = lof_pkg::LOF_REC_NONE;
		if (!sense_check_disable_i) begin
			rsp[lof_pkg::SRC_SENSE].gate   = lof_pkg::LOF_GATE_HIZ;
			rsp[lof_pkg::SRC_SENSE].report = 1'b1;
			rsp[lof_pkg::SRC_SENSE].rec    = lof_pkg::LOF_REC_LATCH;
			if (sense_recovery_select_i == lof_pkg::SNS_SEL_RETRY) begin
				rsp[lof_pkg::SRC_SENSE].rec = lof_pkg::LOF_REC_RETRY;
			end
		end
	end

	assign rsp[lof_pkg::SRC_STALL] = decode_sel(stall_response_select_i);
	assign rsp[lof_pkg::SRC_CMP]   = decode_sel(comparator_stall_response_select_i);
	assign rsp[lof_pkg::SRC_SMP]   = decode_sel(sampled_stall_response_select_i);

	// Flatten responses into masks
	always_comb begin
		for (int i = 0; i < lof_pkg::NSRC; i++) begin
			is_latch[i] = rsp[i].rec == lof_pkg::LOF_REC_LATCH;
			is_retry[i] = rsp[i].rec == lof_pkg::LOF_REC_RETRY;
			is_hiz[i]   = rsp[i].gate == lof_pkg::LOF_GATE_HIZ;
			is_brake[i] = rsp[i].gate == lof_pkg::LOF_GATE_BRAKE;
			is_rep[i]   = rsp[i].report;
		end
	end

	// ****************************************************************
	// Held faults
	// ****************************************************************
	// Next state; a live condition wins over any clear
	always_comb begin
		for (int i = 0; i < lof_pkg::NSRC; i++) begin
			if (!is_rep[i]) begin
				held_d[i] = 1'b0;
			end else if (cond[i]) begin
				held_d[i] = 1'b1;
			end else if (is_latch[i]) begin
				held_d[i] = held_q[i] & !fault_clear_command_i;
			end else if (is_retry[i]) begin
				held_d[i] = held_q[i] & !fault_clear_command_i & !retry_done;
			end else begin
				held_d[i] = 1'b0;
			end
		end
	end

	// Fault state register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			held_q <= '0;
		end else begin
			held_q <= held_d;
		end
	end

	// ****************************************************************
	// Retry timer
	// ****************************************************************
	assign any_ret_cond = |(cond & is_retry);
	assign ret_pend     = |(held_q & is_retry);
	assign retry_done   = retry_cnt_q == lof_pkg::RTRY_W'(RETRY_CYCLES - 1);

	// restart while any retry fault persists
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			retry_cnt_q <= '0;
		end else if (any_ret_cond || !ret_pend || fault_clear_command_i) begin
			retry_cnt_q <= '0;
		end else if (!retry_done) begin
			retry_cnt_q <= retry_cnt_q + 1'b1;
		end
	end

	// ****************************************************************
	// Gate action priority
	// ****************************************************************
	assign lat_mask = held_q & is_latch;

	// latched faults take over retry faults
	always_comb begin
		sel_mask = (|lat_mask) ? lat_mask : (held_q & is_retry);
		if (|(sel_mask & is_hiz)) begin
			gmode = lof_pkg::LOF_GATE_HIZ;
		end else if (|(sel_mask & is_brake)) begin
			gmode = lof_pkg::LOF_GATE_BRAKE;
		end else begin
			gmode = lof_pkg::LOF_GATE_RUN;
		end
	end

	// Gate outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gates_q.high_side_gate_output <= lof_pkg::RST_GATE;
			gates_q.low_side_gate_output  <= lof_pkg::RST_GATE;
		end else begin
			case (gmode)
				lof_pkg::LOF_GATE_HIZ: begin
					gates_q.high_side_gate_output <= lof_pkg::RST_GATE;
					gates_q.low_side_gate_output  <= lof_pkg::RST_GATE;
				end
				// Low side on, high side off
				lof_pkg::LOF_GATE_BRAKE: begin
					gates_q.high_side_gate_output <= lof_pkg::RST_GATE;
					gates_q.low_side_gate_output  <= lof_pkg::LS_ALL_ON;
				end
				// Normal commutation
				default: begin
					gates_q <= pwm_i;
				end
			endcase
		end
	end

	// ****************************************************************
	// Reporting
	// ****************************************************************
	// pin and status follow held faults
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flt_n_q  <= lof_pkg::RST_FLT_N;
			drv_st_q <= 1'b0;
			ctl_st_q <= lof_pkg::RST_STATUS;
		end else begin
			flt_n_q  <= !(|(held_q & is_rep));
			drv_st_q <= held_q[lof_pkg::SRC_SENSE];
			ctl_st_q <= held_q[lof_pkg::SRC_SMP:lof_pkg::SRC_STALL];
		end
	end

	assign gates_o                = gates_q;
	assign fault_indicator_n_o    = flt_n_q;
	assign drv_fault_status_o     = drv_st_q;
	assign control_fault_status_o = ctl_st_q;
	assign retry_pending_o        = ret_pend;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_sense_latch_low: assert property (
		(cond[0] && sense_recovery_select_i != lof_pkg::SNS_SEL_RETRY) |-> ##2
		(gates_o == '0 && !fault_indicator_n_o && drv_fault_status_o))
		else $error("sense latch did not pull gates low");

	a_sense_retry_wait: assert property (
		(held_q[0] && !sense_check_disable_i && sense_recovery_select_i
		 && !fault_clear_command_i) ##1 !held_q[0] |-> $past(retry_done))
		else $error("sense retry released early");

	a_sense_trip_set: assert property (
		cond[0] |=> held_q[0])
		else $error("sense trip not taken");

	a_stall_detect: assert property (
		(cond[1] && !stall_response_select_i[3]) |=> held_q[1])
		else $error("stall not detected");

	a_latch_hold: assert property (
		(held_q[1] && stall_response_select_i[3:2] == 2'b00
		 && !fault_clear_command_i) |=> held_q[1])
		else $error("latched stall dropped");

	a_brake_gates: assert property (
		(gmode == lof_pkg::LOF_GATE_BRAKE) |=>
		(gates_o.low_side_gate_output == 3'h7 && gates_o.high_side_gate_output == 3'h0))
		else $error("brake pattern wrong");

	a_retry_low: assert property (
		(held_q[1] && stall_response_select_i[3:1] == 3'b010 && lat_mask == '0)
		|=> gates_o == '0)
		else $error("retry stall did not pull low");

	a_report_pin: assert property (
		(cond[1] && stall_response_select_i == 4'h8) |-> ##2 !fault_indicator_n_o)
		else $error("report only stall not shown");

	a_stall_silent: assert property (
		(stall_response_select_i > 4'h8) |=> !held_q[1])
		else $error("ignored stall was held");

	a_sampled_report: assert property (
		(cond[3] && !sampled_stall_response_select_i[3]) |-> ##2
		(!fault_indicator_n_o && control_fault_status_o[2]))
		else $error("sampled limit not reported");

	a_clear_latched: assert property (
		(held_q[0] && is_latch[0] && !cond[0] && fault_clear_command_i) |=> !held_q[0])
		else $error("clear did not release latch");

	a_retry_count: assert property (
		(retry_cnt_q != '0) |-> !$past(any_ret_cond))
		else $error("retry counted during fault");

	c_latch_hiz:  cover property (lat_mask != '0 ##1 gates_o == '0);
	c_brake:      cover property (gmode == lof_pkg::LOF_GATE_BRAKE);
	c_retry_rel:  cover property (ret_pend && retry_done ##1 !ret_pend);
	c_report_run: cover property (!fault_indicator_n_o && gmode == lof_pkg::LOF_GATE_RUN);

endmodule

// [bench/lof_bridge_model.sv]
`timescale 1ns/10ps
// ****
// Half-bridge stage and phase comparator
// ****
module lof_bridge_model #(
	parameter int CUR_W = 12
) (
	// Clock
	input  wire logic                clk_i,
	// Gate drive from the block
	input  wire lof_pkg::lof_gates_s gates_i,
	// Analog phase current and comparator level
	input  wire logic [CUR_W-1:0]    current_i,
	input  wire logic [CUR_W-1:0]    level_i,
	// Comparator pin and bridge state
	output logic                     trip_o,
	output logic [2:0]               hiz_o
);
	// phase floats only with both gates low
	assign hiz_o = ~(gates_i.high_side_gate_output | gates_i.low_side_gate_output);

	always_ff @(posedge clk_i) begin
		trip_o <= (current_i > level_i);
	end
endmodule

// [bench/test_lof_fault_resp.sv]
`timescale 1ns/10ps
module test_lof_fault_resp;
	// ****
	// Signals
	// ****
	typedef struct packed {
		lof_pkg::lof_gates_s gates;
		logic [2:0]          hiz;
		logic                flt_n;
		logic [3:0]          stat;
		logic                rp;
	} lof_exp_s;
	localparam int RT = 16;            // Shortened retry interval
	logic                clk_i, rst_i;  // Clock and reset
	logic [7:0]          sv, stl;       // Sense sample and trip level
	logic                sdis, ssel;    // Sense disable and recovery
	logic                spd, nom, bemf; // Stall symptoms
	logic                cmp, clr;      // Comparator pin, clear
	logic [3:0]          stsel, cmsel, smsel; // Response selects
	logic [11:0]         pc, plim, cc, clim;  // Currents and limits
	lof_pkg::lof_gates_s pwm, gates;    // Normal and actual drive
	logic                fn, dst, rp;   // Reporting outputs
	logic [2:0]          cst, hiz;      // Status and bridge state
	lof_exp_s            q[$];          // Expected results
	lof_exp_s            got;           // Observed result
	logic                chk;           // Result ready strobe
	int                  fails, n_compared, cyc, nsym;

	assign got = {gates, hiz, fn, cst, dst, rp};

	// ****
	// Design and bridge
	// ****
	lof_fault_resp #(.RETRY_CYCLES(RT)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .sense_volt_i(sv), .sense_trip_level_i(stl),
		.sense_check_disable_i(sdis), .sense_recovery_select_i(ssel),
		.speed_abnormal_i(spd), .no_motor_i(nom), .bemf_abnormal_i(bemf),
		.stall_response_select_i(stsel), .comparator_stall_trip_i(cmp),
		.comparator_stall_response_select_i(cmsel), .phase_current_i(pc),
		.sampled_stall_current_limit_i(plim), .sampled_stall_response_select_i(smsel),
		.fault_clear_command_i(clr), .pwm_i(pwm), .gates_o(gates),
		.fault_indicator_n_o(fn), .drv_fault_status_o(dst),
		.control_fault_status_o(cst), .retry_pending_o(rp)
	);
	lof_bridge_model bridge (
		.clk_i(clk_i), .gates_i(gates), .current_i(cc), .level_i(clim),
		.trip_o(cmp), .hiz_o(hiz)
	);

	// ****
	// Tasks
	// ****
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Note one expected result for the monitor
	task automatic expect_out(input logic act, input logic brk, input logic [3:0] stat,
			input logic rpe = 1'b0);
		lof_exp_s e;
		e.gates = !act ? pwm : lof_pkg::lof_gates_s'({3'h0, brk ? lof_pkg::LS_ALL_ON : 3'h0});
		e.hiz = ~(e.gates.high_side_gate_output | e.gates.low_side_gate_output);
		e.flt_n = (stat == 4'h0);
		e.stat = stat;
		e.rp = rpe;
		q.push_back(e);
		chk <= 1'b1;
		@(posedge clk_i);
		chk <= 1'b0;
	endtask

	// Raise or drop one source's condition
	task automatic set_cond(input int src, input logic on);
		case (src)
			0: sv <= on ? stl + 8'h01 : stl;
			1: {spd, nom, bemf} <= on ? 3'(1 << (nsym % 3)) : 3'h0;
			2: cc <= on ? clim + 12'h001 : clim;
			default: pc <= on ? plim + 12'h001 : plim;
		endcase
		if (on && src == 1) begin
			nsym++;
		end
	endtask

	// One source at one select, from fault to recovery
	task automatic run_case(input int src, input logic [3:0] sel);
		logic       act, brk, rty;
		logic [3:0] st;
		int         lat;
		act = (src == 0) || (sel < 4'h8);
		brk = (src != 0) && sel[1];
		rty = (src == 0) ? sel[0] : sel[2];
		st = ((src == 0) || (sel <= 4'h8)) ? 4'(1 << src) : 4'h0;
		lat = (src == 2) ? 8 : 4;
		// Park every source at zero in the same step as the new limits land
		{sv, spd, nom, bemf, cc, pc} <= '0;
		pwm <= lof_pkg::lof_gates_s'(6'($urandom));
		stl <= 8'($urandom_range(254));
		clim <= 12'($urandom_range(4094));
		plim <= 12'($urandom_range(4094));
		sdis <= 1'b0;
		ssel <= sel[0];
		{stsel, cmsel, smsel} <= {sel, sel, sel};
		tick(1);
		set_cond(src, 1'b0);
		tick(2);
		set_cond(src, 1'b1);
		tick(lat);
		expect_out(act, brk, st, act && rty);
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		tick(3);
		expect_out(act, brk, st, act && rty);
		set_cond(src, 1'b0);
		tick(lat + 2);
		if (act && !rty) begin
			expect_out(act, brk, st);
			clr <= 1'b1;
			tick(1);
			clr <= 1'b0;
			tick(3);
		end else if (act) begin
			expect_out(act, brk, st, 1'b1);
			tick(RT + 2);
		end
		expect_out(1'b0, 1'b0, 4'h0);
		$display("test src %0d sel %0h done", src, sel);
	endtask

	// Compare one observed result with the oldest note
	task automatic compare_out(input lof_exp_s e);
		n_compared++;
		if (got !== e) begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, e);
		end
	endtask

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ****
	// Monitor, clock and timeout
	// ****
	always @(negedge clk_i) begin
		if (chk === 1'b1) begin
			if (q.size() == 0) begin
				fails++;
				$display("[FAIL] t=%0t got %h exp none", $time, got);
			end else begin
				compare_out(q.pop_front());
			end
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end

	// ****
	// Main sequence
	// ****
	initial begin
		rst_i = 1'b1;
		{sv, stl, sdis, ssel, spd, nom, bemf, clr, chk} = '0;
		{stsel, cmsel, smsel, pc, plim, cc, clim} = '0;
		pwm = '0;
		void'($urandom(32'h8061));
		tick(20);
		rst_i <= 1'b0;
		tick(2);
		expect_out(1'b0, 1'b0, 4'h0);
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < ((s == 0) ? 2 : 16); k++) begin
				run_case(s, 4'(k));
			end
		end
		// Sense check disabled: no report, no action
		sdis <= 1'b1;
		set_cond(0, 1'b1);
		tick(4);
		expect_out(1'b0, 1'b0, 4'h0);
		$display("test sense disabled done");
		set_cond(0, 1'b0);
		// Latched stall with a braking retry on the sampled limit
		{stsel, smsel} <= {4'h0, 4'h6};
		tick(2);
		set_cond(1, 1'b1);
		set_cond(3, 1'b1);
		tick(4);
		expect_out(1'b1, 1'b0, 4'hA, 1'b1);
		set_cond(1, 1'b0);
		set_cond(3, 1'b0);
		tick(RT + 6);
		expect_out(1'b1, 1'b0, 4'h2);
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		tick(3);
		expect_out(1'b0, 1'b0, 4'h0);
		$display("test priority done");
		tick(2);
		complete_run();
	end
endmodule
